// [hdl/wdg_pkg.sv]
// Constants, register map and types of the watchdog timer
package wdg_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int RC_FREQ_HZ = 32000;
    localparam int BASE_PERIOD_5BIT_US = 1000;
    localparam int BASE_PERIOD_7BIT_US = 4000;
    // Eight bits so that a ratio of 128 is held whole
    localparam logic [7:0] PRE_DIV_5BIT = 8'(BASE_PERIOD_5BIT_US * RC_FREQ_HZ / 1000000);
    localparam logic [7:0] PRE_DIV_7BIT = 8'(BASE_PERIOD_7BIT_US * RC_FREQ_HZ / 1000000);

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFF_CONFIG = 8'h00;
    localparam logic [7:0] OFF_RST_CTRL = 8'h04;
    localparam logic [7:0] OFF_INT_STATUS = 8'h08;
    localparam logic [7:0] OFF_INT_MASK = 8'h0c;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int CFG_HW_EN_BIT = 7;
    localparam int CFG_PRESCALE_BIT = 4;
    localparam int CFG_POST_LSB = 0;
    localparam int RC_SW_EN_BIT = 5;
    localparam int RC_TIMEOUT_BIT = 4;
    localparam int RC_SLEEP_BIT = 3;
    localparam int RC_IDLE_BIT = 2;
    localparam int INT_TIMEOUT_BIT = 0;
    localparam int INT_WAKE_BIT = 1;

    // ------------------------------------------------------------
    // Values after reset, AXI response codes and power states
    // ------------------------------------------------------------
    localparam logic [7:0] CFG_RESET = 8'h1f;
    localparam logic [1:0] INT_MASK_RESET = 2'h0;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        PS_RUN = 3'h1,
        PS_SLEEP = 3'h2,
        PS_IDLE = 3'h4
    } wdg_pstate_t;

endpackage

// [hdl/wdg_edge_sync.sv]
// Three-stage synchroniser with rising-edge pulse for the RC clock pin
`timescale 1ns/10ps
module wdg_edge_sync (
    input wire logic clk,
    input wire logic nrst,
    input wire logic async_in,
    output logic rise_pulse
);

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic level;
        logic pulse;
    } wdg_sync_t;

    wdg_sync_t st_r;
    wdg_sync_t st_nxt;

    // ------------------------------------------------------------
    // Stage one feeds only stage two
    // ------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        st_nxt.s1 = async_in;
        st_nxt.s2 = st_r.s1;
        st_nxt.s3 = st_r.s2;
        st_nxt.pulse = 1'b0;
        if (st_r.s2 == st_r.s3) begin
            st_nxt.level = st_r.s2;
            st_nxt.pulse = st_r.s2 && !st_r.level;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign rise_pulse = st_r.pulse;

endmodule

// [hdl/wdg_timer.sv]
// Watchdog timer with prescaler, postscaler, power-save wake and AXI4-Lite registers
//
// Function
// - The watchdog counts edges of the low-power RC clock and enabling it turns that oscillator on.
// - The prescaler divides by 32 or by 128 as config bit 4 selects.
// - With a 32 kHz clock the prescaler alone gives 1 ms or 4 ms.
// - A postscaler chosen by config bits 3:0 divides further from 1:1 to 1:32768.
// - Counter, prescaler and postscaler clear on any device reset and on clock-switch completion.
// - They also clear on power-save entry, on leaving sleep or idle, and on the kick instruction while running.
// - An enabled watchdog keeps counting in sleep and idle and its time-out wakes the core.
// - Config bit 7 set forces the watchdog on whatever the software enable holds.
// - With config bit 7 clear the watchdog runs only while the software enable is set.
// - Every device reset clears the software enable.
// - The time-out flag is set on each time-out and only software clears it.
//
// Added by the designer: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/10ps
module wdg_timer (
    input wire logic clk,
    input wire logic nrst,
    input wire logic low_power_rc_clock,
    input wire logic dev_reset,
    input wire logic clk_switch_done,
    input wire logic kick_instruction,
    input wire logic power_save_instruction,
    input wire logic power_save_idle,
    input wire logic wake_event,
    output logic rc_osc_enable,
    output logic wake_request,
    output logic wdt_reset_request,
    output logic irq,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);

    typedef struct packed {
        wdg_pkg::wdg_pstate_t pst;
        logic [7:0] cfg;
        logic sw_en;
        logic flag_to;
        logic flag_sleep;
        logic flag_idle;
        logic [6:0] pre;
        logic [14:0] post;
        logic [1:0] int_st;
        logic [1:0] int_mask;
        logic osc_en;
        logic wake;
        logic rst_req;
        logic irq;
        logic aw_rdy;
        logic bvalid;
        logic [1:0] bresp;
        logic ar_rdy;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
    } wdg_state_t;

    wdg_state_t st_r;
    wdg_state_t st_nxt;
    logic rc_tick;
    logic enabled;
    logic [6:0] pre_limit;
    logic [14:0] post_limit;
    logic timeout;
    logic clr;
    logic wr_go;
    logic rd_go;

    // Byte offset decode shared by the read and write paths
    function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
        hit = (addr[7:2] == off[7:2]);
    endfunction

    function automatic logic mapped(input logic [7:0] addr);
        mapped = hit(addr, wdg_pkg::OFF_CONFIG) || hit(addr, wdg_pkg::OFF_RST_CTRL) ||
                 hit(addr, wdg_pkg::OFF_INT_STATUS) || hit(addr, wdg_pkg::OFF_INT_MASK);
    endfunction

    wdg_edge_sync u_rc_sync (
        .clk(clk),
        .nrst(nrst),
        .async_in(low_power_rc_clock),
        .rise_pulse(rc_tick)
    );

    // ------------------------------------------------------------
    // Count chain
    // ------------------------------------------------------------
    assign enabled = st_r.cfg[wdg_pkg::CFG_HW_EN_BIT] || st_r.sw_en;
    assign pre_limit = st_r.cfg[wdg_pkg::CFG_PRESCALE_BIT] ?
        7'(wdg_pkg::PRE_DIV_7BIT - 8'h1) : 7'(wdg_pkg::PRE_DIV_5BIT - 8'h1);
    assign post_limit = 15'((16'h1 << st_r.cfg[3:0]) - 16'h1);
    // Compare with >= so a smaller ratio written mid-count still expires
    assign timeout = enabled && rc_tick && st_r.pre >= pre_limit && st_r.post >= post_limit;

    // Every event that restarts the count
    assign clr = dev_reset || clk_switch_done || timeout ||
        power_save_instruction ||
        (kick_instruction && st_r.pst == wdg_pkg::PS_RUN) ||
        (wake_event && st_r.pst != wdg_pkg::PS_RUN);

    assign wr_go = s_axi_awvalid && s_axi_wvalid && st_r.aw_rdy;
    assign rd_go = s_axi_arvalid && st_r.ar_rdy;

    always_comb begin
        st_nxt = st_r;
        st_nxt.wake = 1'b0;
        st_nxt.rst_req = 1'b0;
        st_nxt.osc_en = enabled;

        // --------------------------------------------------------
        // Prescaler and postscaler
        // --------------------------------------------------------
        if (clr || !enabled) begin
            st_nxt.pre = '0;
            st_nxt.post = '0;
        end else if (rc_tick) begin
            if (st_r.pre >= pre_limit) begin
                st_nxt.pre = '0;
                st_nxt.post = st_r.post + 15'h1;
            end else begin
                st_nxt.pre = st_r.pre + 7'h1;
            end
        end

        // --------------------------------------------------------
        // Power state
        // --------------------------------------------------------
        unique case (st_r.pst)
            wdg_pkg::PS_RUN: begin
                if (timeout) begin
                    st_nxt.rst_req = 1'b1;
                end else if (power_save_instruction) begin
                    st_nxt.pst = power_save_idle ? wdg_pkg::PS_IDLE : wdg_pkg::PS_SLEEP;
                end
            end
            wdg_pkg::PS_SLEEP, wdg_pkg::PS_IDLE: begin
                if (timeout || wake_event) begin
                    st_nxt.pst = wdg_pkg::PS_RUN;
                    st_nxt.wake = 1'b1;
                end
            end
            default: begin
                st_nxt.pst = wdg_pkg::PS_RUN;
            end
        endcase
        if (dev_reset) begin
            st_nxt.pst = wdg_pkg::PS_RUN;
            st_nxt.sw_en = 1'b0;
        end

        // --------------------------------------------------------
        // Register writes
        // --------------------------------------------------------
        st_nxt.aw_rdy = s_axi_awvalid && s_axi_wvalid && !st_r.aw_rdy && !st_r.bvalid;
        if (st_r.bvalid && s_axi_bready) begin
            st_nxt.bvalid = 1'b0;
        end
        if (wr_go) begin
            st_nxt.aw_rdy = 1'b0;
            st_nxt.bvalid = 1'b1;
            st_nxt.bresp = mapped(s_axi_awaddr) ? wdg_pkg::RESP_OKAY : wdg_pkg::RESP_SLVERR;
            if (s_axi_wstrb[0]) begin
                if (hit(s_axi_awaddr, wdg_pkg::OFF_CONFIG)) begin
                    st_nxt.cfg = s_axi_wdata[7:0];
                end
                if (hit(s_axi_awaddr, wdg_pkg::OFF_RST_CTRL)) begin
                    st_nxt.sw_en = s_axi_wdata[wdg_pkg::RC_SW_EN_BIT] && !dev_reset;
                    st_nxt.flag_to = s_axi_wdata[wdg_pkg::RC_TIMEOUT_BIT];
                    st_nxt.flag_sleep = s_axi_wdata[wdg_pkg::RC_SLEEP_BIT];
                    st_nxt.flag_idle = s_axi_wdata[wdg_pkg::RC_IDLE_BIT];
                end
                if (hit(s_axi_awaddr, wdg_pkg::OFF_INT_STATUS)) begin
                    st_nxt.int_st = st_r.int_st & ~s_axi_wdata[1:0];
                end
                if (hit(s_axi_awaddr, wdg_pkg::OFF_INT_MASK)) begin
                    st_nxt.int_mask = s_axi_wdata[1:0];
                end
            end
        end

        // --------------------------------------------------------
        // Hardware sets win over software clears
        // --------------------------------------------------------
        if (timeout) begin
            st_nxt.flag_to = 1'b1;
            st_nxt.int_st[wdg_pkg::INT_TIMEOUT_BIT] = 1'b1;
        end
        if (st_r.pst == wdg_pkg::PS_RUN && power_save_instruction && !timeout) begin
            st_nxt.flag_sleep = st_nxt.flag_sleep || !power_save_idle;
            st_nxt.flag_idle = st_nxt.flag_idle || power_save_idle;
        end
        if (st_nxt.wake) begin
            st_nxt.int_st[wdg_pkg::INT_WAKE_BIT] = 1'b1;
        end
        st_nxt.irq = |(st_nxt.int_st & st_nxt.int_mask);

        // --------------------------------------------------------
        // Register reads
        // --------------------------------------------------------
        st_nxt.ar_rdy = s_axi_arvalid && !st_r.ar_rdy && !st_r.rvalid;
        if (st_r.rvalid && s_axi_rready) begin
            st_nxt.rvalid = 1'b0;
        end
        if (rd_go) begin
            st_nxt.ar_rdy = 1'b0;
            st_nxt.rvalid = 1'b1;
            st_nxt.rresp = mapped(s_axi_araddr) ? wdg_pkg::RESP_OKAY : wdg_pkg::RESP_SLVERR;
            st_nxt.rdata = 32'h0;
            if (hit(s_axi_araddr, wdg_pkg::OFF_CONFIG)) begin
                st_nxt.rdata[7:0] = st_r.cfg;
            end
            if (hit(s_axi_araddr, wdg_pkg::OFF_RST_CTRL)) begin
                st_nxt.rdata[wdg_pkg::RC_SW_EN_BIT] = st_r.sw_en;
                st_nxt.rdata[wdg_pkg::RC_TIMEOUT_BIT] = st_r.flag_to;
                st_nxt.rdata[wdg_pkg::RC_SLEEP_BIT] = st_r.flag_sleep;
                st_nxt.rdata[wdg_pkg::RC_IDLE_BIT] = st_r.flag_idle;
            end
            if (hit(s_axi_araddr, wdg_pkg::OFF_INT_STATUS)) begin
                st_nxt.rdata[1:0] = st_r.int_st;
            end
            if (hit(s_axi_araddr, wdg_pkg::OFF_INT_MASK)) begin
                st_nxt.rdata[1:0] = st_r.int_mask;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            st_r <= '0;
            st_r.pst <= wdg_pkg::PS_RUN;
            st_r.cfg <= wdg_pkg::CFG_RESET;
            st_r.int_mask <= wdg_pkg::INT_MASK_RESET;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign rc_osc_enable = st_r.osc_en;
    assign wake_request = st_r.wake;
    assign wdt_reset_request = st_r.rst_req;
    assign irq = st_r.irq;
    assign s_axi_awready = st_r.aw_rdy;
    assign s_axi_wready = st_r.aw_rdy;
    assign s_axi_bvalid = st_r.bvalid;
    assign s_axi_bresp = st_r.bresp;
    assign s_axi_arready = st_r.ar_rdy;
    assign s_axi_rvalid = st_r.rvalid;
    assign s_axi_rresp = st_r.rresp;
    assign s_axi_rdata = st_r.rdata;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    sequence s_sleep_timeout;
        timeout && st_r.pst != wdg_pkg::PS_RUN;
    endsequence
    sequence s_woken;
        wake_request ##1 (st_r.pst == wdg_pkg::PS_RUN && !wake_request);
    endsequence

    a_osc_on_enable: assert property (enabled |=> rc_osc_enable)
        else $error("oscillator not enabled with watchdog");
    a_pre_step: assert property (rc_tick && enabled && !clr && st_r.pre < pre_limit
        |=> st_r.pre == $past(st_r.pre) + 7'h1)
        else $error("prescaler did not step");
    a_pre_limit: assert property (st_r.pre <= 7'd127 && (pre_limit == 7'd31 ||
        pre_limit == 7'd127))
        else $error("prescaler limit not 32 or 128");
    a_post_step: assert property (rc_tick && enabled && !clr && st_r.pre >= pre_limit
        |=> st_r.post == $past(st_r.post) + 15'h1)
        else $error("postscaler did not step on prescaler wrap");
    a_clear_count: assert property ((clk_switch_done || dev_reset ||
        (kick_instruction && st_r.pst == wdg_pkg::PS_RUN)) |=> st_r.pre == 7'h0 && st_r.post == 15'h0)
        else $error("count not cleared");
    a_ps_entry: assert property (power_save_instruction && st_r.pst == wdg_pkg::PS_RUN &&
        !timeout && !dev_reset
        |=> st_r.pre == 7'h0 && st_r.pst != wdg_pkg::PS_RUN)
        else $error("power-save entry mishandled");
    a_sleep_wake: assert property (s_sleep_timeout |=> s_woken)
        else $error("no wake on sleep time-out");
    a_enable_src: assert property (!st_r.cfg[wdg_pkg::CFG_HW_EN_BIT] && !st_r.sw_en
        |=> st_r.pre == 7'h0 && st_r.post == 15'h0)
        else $error("count moved while disabled");
    a_sw_reset: assert property (dev_reset |=> !st_r.sw_en)
        else $error("software enable survived reset");
    a_flag_sticky: assert property (timeout || (st_r.flag_to && !wr_go) |=> st_r.flag_to)
        else $error("time-out flag not held");
    a_run_reset: assert property (timeout && st_r.pst == wdg_pkg::PS_RUN
        |=> wdt_reset_request ##1 !wdt_reset_request)
        else $error("no reset request on run time-out");

endmodule

// [verification/wdg_core_model.sv]
// Behavioural model of the processor core that issues the watchdog's instruction pulses
`timescale 1ns/10ps
module wdg_core_model (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [2:0] cmd,
    input wire logic wdt_reset_request,
    output logic kick_instruction,
    output logic power_save_instruction,
    output logic power_save_idle,
    output logic wake_event,
    output logic clk_switch_done,
    output logic dev_reset
);
    // ------------------------------------------------------------
    // Instruction decode, one pulse per command
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!nrst) begin
            kick_instruction <= 1'b0;
            power_save_instruction <= 1'b0;
            power_save_idle <= 1'b0;
            wake_event <= 1'b0;
            clk_switch_done <= 1'b0;
            dev_reset <= 1'b0;
        end else begin
            kick_instruction <= (cmd == 3'h1);
            power_save_instruction <= (cmd == 3'h2) || (cmd == 3'h3);
            power_save_idle <= (cmd == 3'h3);
            wake_event <= (cmd == 3'h4);
            clk_switch_done <= (cmd == 3'h5);
            // Reset logic answers a time-out request on the next clock
            dev_reset <= wdt_reset_request;
        end
    end
endmodule

// [verification/tb.sv]
// Self-checking testbench of the watchdog timer
`timescale 1ns/10ps
module tb;
    logic clk, nrst, rc;
    logic [2:0] cmd;
    logic kick, psave, pidle, wake_ev, sw_done, dreset;
    logic osc_en, wake_req, rst_req, irq;
    logic [7:0] awaddr, araddr;
    logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    int num_errors = 0, cmp_count = 0, cyc = 0, rc_ticks = 0, rst_cnt = 0, wake_cnt = 0;
    logic [31:0] d;
    logic [1:0] r;
    int n, m;

    wdg_core_model wdg_core_model_i (.clk(clk), .nrst(nrst), .cmd(cmd),
        .wdt_reset_request(rst_req), .kick_instruction(kick), .power_save_instruction(psave),
        .power_save_idle(pidle), .wake_event(wake_ev), .clk_switch_done(sw_done),
        .dev_reset(dreset));
    wdg_timer wdg_timer_i (.clk(clk), .nrst(nrst), .low_power_rc_clock(rc), .dev_reset(dreset),
        .clk_switch_done(sw_done), .kick_instruction(kick), .power_save_instruction(psave),
        .power_save_idle(pidle), .wake_event(wake_ev), .rc_osc_enable(osc_en),
        .wake_request(wake_req), .wdt_reset_request(rst_req), .irq(irq),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

    // ------------------------------------------------------------
    // Clocks, event counters, hang guard
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // Odd half period keeps the RC pin out of phase with clk; stops low while disabled
    initial begin
        rc = 1'b0;
        forever #31 rc = (osc_en === 1'b1) ? ~rc : 1'b0;
    end
    always @(posedge rc) rc_ticks++;
    always @(posedge clk) begin
        cyc++;
        if (rst_req === 1'b1) rst_cnt++;
        if (wake_req === 1'b1) wake_cnt++;
        if (cyc == 90000) begin
            num_errors++;
            end_of_test();
        end
    end

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic ax_wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
        @(posedge clk);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do @(negedge clk); while ((awready & wready) !== 1'b1);
        @(posedge clk);
        awvalid <= 1'b0;
        wvalid <= 1'b0;
        bready <= 1'b1;
        do @(negedge clk); while (bvalid !== 1'b1);
        rs = bresp;
        @(posedge clk);
        bready <= 1'b0;
    endtask
    task automatic ax_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        do @(negedge clk); while (arready !== 1'b1);
        @(posedge clk);
        arvalid <= 1'b0;
        rready <= 1'b1;
        do @(negedge clk); while (rvalid !== 1'b1);
        v = rdata;
        rs = rresp;
        @(posedge clk);
        rready <= 1'b0;
    endtask
    task automatic core(input logic [2:0] c);
        @(posedge clk);
        cmd <= c;
        @(posedge clk);
        cmd <= 3'h0;
    endtask
    task automatic wait_ticks(input int k);
        int t;
        t = rc_ticks + k;
        while (rc_ticks < t) @(posedge clk);
    endtask
    task automatic measure(input logic [7:0] cfg);
        int e, t0, k;
        e = (cfg[4] ? 128 : 32) << cfg[3:0];
        ax_wr(8'h00, {24'h0, cfg}, r);
        ax_wr(8'h04, 32'h20, r);
        t0 = rc_ticks;
        k = rst_cnt;
        @(negedge clk);
        chk("osc_enable", 32'h1, {31'h0, osc_en});
        while (rst_cnt == k) @(posedge clk);
        cmp_count++;
        if (rc_ticks - t0 < e - 1 || rc_ticks - t0 > e + 1) begin
            num_errors++;
            $display("BAD timeout_ticks expected %0d seen %0d", e, rc_ticks - t0);
        end
        repeat (4) @(posedge clk);
        ax_rd(8'h04, d, r);
        chk("rst_ctrl_after_timeout", 32'h10, d);
    endtask
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        nrst = 1'b0;
        cmd = 3'h0;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
        awaddr = 8'h0;
        araddr = 8'h0;
        wdata = 32'h0;
        wstrb = 4'hf;
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
        ax_rd(8'h00, d, r);
        chk("config_reset", 32'h1f, d);
        ax_rd(8'h04, d, r);
        chk("rst_ctrl_reset", 32'h0, d);
        ax_rd(8'h0c, d, r);
        chk("mask_reset", 32'h0, d);
        ax_rd(8'h10, d, r);
        chk("unmapped_rresp", 32'h2, {30'h0, r});
        ax_wr(8'h10, 32'h1, r);
        chk("unmapped_bresp", 32'h2, {30'h0, r});
        wstrb <= 4'h0;
        ax_wr(8'h0c, 32'h3, r);
        chk("strobe_bresp", 32'h0, {30'h0, r});
        wstrb <= 4'hf;
        ax_rd(8'h0c, d, r);
        chk("strobe_ignored", 32'h0, d);
        $display("test reset done");
        // Period for every prescale mode and a spread of postscale settings
        measure(8'h00);
        chk("irq_masked", 32'h0, {31'h0, irq});
        ax_wr(8'h0c, 32'h1, r);
        @(negedge clk);
        chk("irq_unmasked", 32'h1, {31'h0, irq});
        ax_wr(8'h08, 32'h1, r);
        @(negedge clk);
        chk("irq_cleared", 32'h0, {31'h0, irq});
        measure(8'h10);
        measure(8'h02);
        measure(8'h13);
        $display("test period done");
        // Kicks and clock switches hold off the time-out
        ax_wr(8'h00, 32'h0, r);
        ax_wr(8'h04, 32'h20, r);
        n = rst_cnt;
        for (int i = 0; i < 6; i++) begin
            wait_ticks(20);
            core(i[0] ? 3'h5 : 3'h1);
        end
        chk("no_reset_while_kicked", n, rst_cnt);
        while (rst_cnt == n) @(posedge clk);
        $display("test kick done");
        // Sleep and idle: counting goes on and the time-out wakes
        for (int c = 2; c <= 3; c++) begin
            ax_wr(8'h04, 32'h20, r);
            core(3'(c));
            ax_rd(8'h04, d, r);
            chk("flag_on_entry", (c == 2) ? 32'h28 : 32'h24, d);
            n = wake_cnt;
            m = rst_cnt;
            while (wake_cnt == n) @(posedge clk);
            chk("reset_in_power_save", m, rst_cnt);
            ax_rd(8'h04, d, r);
            chk("flags_after_wake", (c == 2) ? 32'h38 : 32'h34, d);
            ax_wr(8'h04, 32'h0, r);
            ax_rd(8'h04, d, r);
            chk("flags_cleared", 32'h0, d);
        end
        // Another wake source also leaves power save
        ax_wr(8'h04, 32'h20, r);
        core(3'h2);
        n = wake_cnt;
        core(3'h4);
        repeat (3) @(posedge clk);
        chk("wake_by_event", n + 1, wake_cnt);
        ax_rd(8'h04, d, r);
        chk("no_timeout_flag", 32'h28, d);
        ax_wr(8'h04, 32'h0, r);
        ax_rd(8'h08, d, r);
        chk("int_status", 32'h3, d);
        ax_wr(8'h08, 32'h3, r);
        ax_rd(8'h08, d, r);
        chk("int_status_clear", 32'h0, d);
        chk("irq_after_clear", 32'h0, {31'h0, irq});
        $display("test power_save done");
        // Hardware force enable overrides the software bit
        ax_wr(8'h00, 32'h80, r);
        @(negedge clk);
        chk("osc_forced", 32'h1, {31'h0, osc_en});
        n = rst_cnt;
        while (rst_cnt == n) @(posedge clk);
        ax_wr(8'h00, 32'h0, r);
        repeat (2) @(negedge clk);
        chk("osc_off", 32'h0, {31'h0, osc_en});
        $display("test force_enable done");
        end_of_test();
    end
endmodule
